/* File: rtl/csup_regs.svh */
// Constants for the compressor supervisor
// Summary of operation
// - Local mode: off button stops everything
// - Remote mode: only connector run/halt act
// - Off plus cold-head line: on runs head
// - Head-only run ends on off or 30 min
// - Power-up detects power loss; switch-off counts
// - After power loss, delayed automatic restart
// - Helium trip: five retries, 20 min apart
// - Reset or power loss clears helium trip
// - Remote: ignore reset first 19 min
// - Up/down scroll fixed list, wrapping
// - 30 s idle returns to first line
// - Cold-head line listed only when off
// - Faulted point shows error, goes top
// - Newest fault on top, older scrollable
// - Lost sensor shows fail status
// - Helium over 93 C is shutdown
// - Water temp and flow are alarms
// - Return pressure below 15 psig shutdown
// - Phase, motor, cable shutdowns; oil unused
// - Shutdown stops motors, signals connector, display
// - Local clearing only in local mode
// - Remote pulse, both buttons, power clear
// - Panel on/off only in local mode
// - Mode switch sampled only at power-up
`ifndef CSUP_REGS_SVH
`define CSUP_REGS_SVH
`define CSUP_CLK_NS        4
`define CSUP_SEC_NS        1000000000
`define CSUP_CH_RUN_S      11'd1800
`define CSUP_RETRY_S       11'd1200
`define CSUP_RESET_HOLD_S  11'd1140
`define CSUP_RESTART_S     11'd5
`define CSUP_IDLE_S        5'd30
`define CSUP_RETRY_MAX     3'd5
`define CSUP_ADR_CTRL      4'h0
`define CSUP_ADR_STATUS    4'h4
`define CSUP_ADR_DISP      4'h8
`define CSUP_CTRL_RESET    2'h3
`define CSUP_PT_HELIUM     3'd0
`define CSUP_PT_WTEMP      3'd1
`define CSUP_PT_WFLOW      3'd2
`define CSUP_PT_OIL        3'd6
`define CSUP_SHUTDOWN_MASK 8'hB9
`define CSUP_ALARM_MASK    8'h06
`define CSUP_LINE_ET       4'd0
`define CSUP_LINE_PT0      4'd1
`define CSUP_LINE_CH       4'd11
`define CSUP_LINE_LAST_RUN 4'd10
`endif

/* File: rtl/csup_pkg.sv */
// Types for the compressor supervisor
package csup_pkg;
    typedef enum logic [4:0] {
        ST_OFF     = 5'h01,
        ST_RUN     = 5'h02,
        ST_CH_ONLY = 5'h04,
        ST_PWR_DLY = 5'h08,
        ST_HE_WAIT = 5'h10
    } csup_state_t;
    typedef enum logic [1:0] {
        PS_OK   = 2'h0,
        PS_ERR  = 2'h1,
        PS_FAIL = 2'h2,
        PS_NONE = 2'h3
    } csup_pstat_t;
endpackage

/* File: rtl/csup_supervisor.sv */
// Compressor supervisor: run control, fault latching, status display, Wishbone
`timescale 1ns/1ps
`default_nettype none
`include "csup_regs.svh"
module csup_supervisor #(
    parameter int SEC_CYCLES = `CSUP_SEC_NS / `CSUP_CLK_NS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Front panel
    input  wire logic        btn_on,
    input  wire logic        btn_off,
    input  wire logic        btn_up,
    input  wire logic        btn_down,
    input  wire logic        mode_remote,
    // Diagnostic connector, remote side
    input  wire logic        rem_run,
    input  wire logic        rem_halt,
    input  wire logic        rem_clear,
    output logic             rem_alarm,
    output logic             rem_shutdown,
    // Power-loss record kept across power cycles
    input  wire logic        nv_clean_stop,
    output logic             nv_clean_stop_set,
    // Fault comparators, one bit per monitored point
    input  wire logic        he_temp_hi,
    input  wire logic        water_temp_hi,
    input  wire logic        water_flow_lo,
    input  wire logic        motor_prot_open,
    input  wire logic        phase_fault,
    input  wire logic        ret_press_lo,
    input  wire logic        cable_mismatch,
    input  wire logic [7:0]  sensor_lost,
    // Outputs
    output logic             comp_on,
    output logic             coldhead_on,
    output logic [3:0]       disp_line,
    output logic [1:0]       disp_status
);

    csup_pkg::csup_state_t state_reg;
    csup_pkg::csup_state_t state_next;

    logic [31:0] sec_div_reg;
    logic        sec_tick;
    logic        started_reg;
    logic        remote_reg;
    logic [1:0]  ctrl_reg;
    logic [10:0] sec_cnt_reg;
    logic [2:0]  retry_reg;
    logic [7:0]  err_reg;
    logic [7:0]  fault_now;
    logic [7:0]  fault_new;
    logic [7:0]  fault_prev_reg;
    logic [2:0]  top_pt_reg;
    logic        any_err;
    logic        shutdown;
    logic        clear_req;
    logic        he_clear;
    logic [3:0]  line_reg;
    logic [4:0]  idle_reg;
    logic        idle_run_reg;
    logic        on_q_reg, off_q_reg, up_q_reg, dn_q_reg, clr_q_reg;
    logic        on_p, off_p, up_p, dn_p, clr_p, both_p;
    logic        run_cmd, stop_cmd;
    logic        timer_done;

    // Point index to display line
    function automatic logic [3:0] pt_line(input logic [2:0] pt);
        pt_line = `CSUP_LINE_PT0 + {1'b0, pt};
    endfunction

    // Whole seconds from the system clock
    always_ff @(posedge clk) begin
        if (rst || sec_tick) begin
            sec_div_reg <= 32'h0;
        end else begin
            sec_div_reg <= sec_div_reg + 32'h1;
        end
    end
    assign sec_tick = (sec_div_reg == SEC_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            started_reg <= 1'b0;
            remote_reg  <= 1'b0;
        end else if (!started_reg) begin
            started_reg <= 1'b1;
            remote_reg  <= mode_remote;
        end
    end

    // Button edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            on_q_reg  <= 1'b0;
            off_q_reg <= 1'b0;
            up_q_reg  <= 1'b0;
            dn_q_reg  <= 1'b0;
            clr_q_reg <= 1'b0;
        end else begin
            on_q_reg  <= btn_on;
            off_q_reg <= btn_off;
            up_q_reg  <= btn_up;
            dn_q_reg  <= btn_down;
            clr_q_reg <= rem_clear;
        end
    end
    assign on_p   = btn_on & ~on_q_reg;
    assign off_p  = btn_off & ~off_q_reg;
    assign up_p   = btn_up & ~up_q_reg;
    assign dn_p   = btn_down & ~dn_q_reg;
    assign clr_p  = rem_clear & ~clr_q_reg;
    // Both held, either edge completes the chord
    assign both_p = btn_up & btn_down & (up_p | dn_p);

    // remote run and halt; panel only when local
    assign run_cmd  = started_reg & (remote_reg ? rem_run : on_p);
    assign stop_cmd = started_reg & (remote_reg ? rem_halt : off_p);

    assign fault_now = {cable_mismatch, 1'b0, ret_press_lo, phase_fault, motor_prot_open,
                        water_flow_lo, water_temp_hi, he_temp_hi}
                       | (sensor_lost & ~(8'h1 << `CSUP_PT_OIL));
    assign fault_new = fault_now & ~fault_prev_reg;

    // local chord only in local mode; remote pulse
    assign clear_req = remote_reg ? clr_p : both_p;
    // remote clear held off early in each retry interval
    assign he_clear  = clear_req && !(remote_reg && state_reg == csup_pkg::ST_HE_WAIT
                                      && sec_cnt_reg > `CSUP_RETRY_S - `CSUP_RESET_HOLD_S);

    // Error latches, a new fault wins over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            err_reg        <= 8'h0;
            fault_prev_reg <= 8'h0;
        end else begin
            fault_prev_reg <= fault_now;
            if (clear_req) begin
                err_reg[7:1] <= fault_now[7:1];
            end else begin
                err_reg[7:1] <= err_reg[7:1] | fault_now[7:1];
            end
            // helium latch, also freed by an automatic retry
            if (he_clear || (state_reg == csup_pkg::ST_HE_WAIT && timer_done)) begin
                err_reg[0] <= fault_now[0];
            end else begin
                err_reg[0] <= err_reg[0] | fault_now[0];
            end
        end
    end

    assign any_err  = |err_reg;
    // shutdown class stops motors; alarms do not
    assign shutdown = |(err_reg & `CSUP_SHUTDOWN_MASK);

    // Connector indications
    always_ff @(posedge clk) begin
        if (rst) begin
            rem_alarm    <= 1'b0;
            rem_shutdown <= 1'b0;
        end else begin
            rem_alarm    <= |(err_reg & `CSUP_ALARM_MASK);
            rem_shutdown <= shutdown;
        end
    end

    // Newest fault becomes the top of the list
    always_ff @(posedge clk) begin
        if (rst) begin
            top_pt_reg <= 3'd0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (fault_new[i]) begin
                    top_pt_reg <= 3'(i);
                end
            end
        end
    end

    assign timer_done = (sec_cnt_reg == 11'd0);

    // Run state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            csup_pkg::ST_OFF: begin
                if (!started_reg) begin
                    state_next = csup_pkg::ST_OFF;
                // head-only start from the selection line
                end else if (!remote_reg && on_p && line_reg == `CSUP_LINE_CH && !shutdown) begin
                    state_next = csup_pkg::ST_CH_ONLY;
                end else if (run_cmd && !shutdown) begin
                    state_next = csup_pkg::ST_RUN;
                end
            end
            csup_pkg::ST_PWR_DLY: begin
                if (shutdown || stop_cmd) begin
                    state_next = csup_pkg::ST_OFF;
                end else if (timer_done) begin
                    state_next = csup_pkg::ST_RUN;
                end
            end
            csup_pkg::ST_RUN: begin
                // helium trip enters the retry wait
                if (err_reg[0] && retry_reg < `CSUP_RETRY_MAX) begin
                    state_next = csup_pkg::ST_HE_WAIT;
                end else if (shutdown || stop_cmd) begin
                    state_next = csup_pkg::ST_OFF;
                end
            end
            csup_pkg::ST_CH_ONLY: begin
                // off press or run timer expiry
                if (off_p || timer_done || shutdown) begin
                    state_next = csup_pkg::ST_OFF;
                end
            end
            csup_pkg::ST_HE_WAIT: begin
                if (stop_cmd) begin
                    state_next = csup_pkg::ST_OFF;
                end else if (!err_reg[0] && !(shutdown & ~err_reg[0])) begin
                    state_next = csup_pkg::ST_RUN;
                end else if (err_reg[0] && retry_reg == `CSUP_RETRY_MAX) begin
                    state_next = csup_pkg::ST_OFF;
                end
            end
            default: begin
                state_next = csup_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= csup_pkg::ST_OFF;
        end else if (!started_reg) begin
            // no clean-stop record means power was lost
            if (!nv_clean_stop && ctrl_reg[0]) begin
                state_reg <= csup_pkg::ST_PWR_DLY;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // Shared seconds timer, loaded on each state entry or retry
    always_ff @(posedge clk) begin
        if (rst || !started_reg) begin
            sec_cnt_reg <= `CSUP_RESTART_S;
        end else if (state_next != state_reg || (state_reg == csup_pkg::ST_HE_WAIT && timer_done)) begin
            case (state_next)
                csup_pkg::ST_CH_ONLY: sec_cnt_reg <= `CSUP_CH_RUN_S;
                csup_pkg::ST_HE_WAIT: sec_cnt_reg <= `CSUP_RETRY_S;
                default:              sec_cnt_reg <= `CSUP_RESTART_S;
            endcase
        end else if (sec_tick && !timer_done) begin
            sec_cnt_reg <= sec_cnt_reg - 11'd1;
        end
    end

    // Retry attempts
    always_ff @(posedge clk) begin
        if (rst || he_clear) begin
            retry_reg <= 3'd0;
        end else if (state_reg == csup_pkg::ST_HE_WAIT && timer_done && ctrl_reg[1]) begin
            retry_reg <= retry_reg + 3'd1;
        end
    end

    // Motor outputs and power-loss record
    always_ff @(posedge clk) begin
        if (rst) begin
            comp_on           <= 1'b0;
            coldhead_on       <= 1'b0;
            nv_clean_stop_set <= 1'b1;
        end else begin
            // motors off on shutdown; head only
            comp_on     <= (state_reg == csup_pkg::ST_RUN) && !shutdown;
            coldhead_on <= (state_reg == csup_pkg::ST_RUN || state_reg == csup_pkg::ST_CH_ONLY)
                           && !shutdown;
            // main switch off leaves the record dirty
            nv_clean_stop_set <= !(state_reg == csup_pkg::ST_RUN || state_reg == csup_pkg::ST_HE_WAIT);
        end
    end

    // Display line selection
    always_ff @(posedge clk) begin
        if (rst) begin
            line_reg     <= `CSUP_LINE_ET;
            idle_reg     <= 5'd0;
            idle_run_reg <= 1'b0;
        end else if (|fault_new) begin
            // faulted point jumps to the top
            line_reg     <= `CSUP_LINE_ET;
            idle_run_reg <= 1'b0;
        end else if ((up_p ^ dn_p) && !both_p) begin
            idle_reg     <= `CSUP_IDLE_S;
            idle_run_reg <= 1'b1;
            // wrap both ways; head line only when off
            if (up_p) begin
                if (line_reg == `CSUP_LINE_ET) begin
                    line_reg <= (state_reg == csup_pkg::ST_OFF) ? `CSUP_LINE_CH : `CSUP_LINE_LAST_RUN;
                end else begin
                    line_reg <= line_reg - 4'd1;
                end
            end else begin
                if (line_reg == `CSUP_LINE_CH ||
                    (line_reg == `CSUP_LINE_LAST_RUN && state_reg != csup_pkg::ST_OFF)) begin
                    line_reg <= `CSUP_LINE_ET;
                end else begin
                    line_reg <= line_reg + 4'd1;
                end
            end
        end else if (idle_run_reg && sec_tick) begin
            // idle timeout back to the first line
            if (idle_reg == 5'd1) begin
                line_reg     <= `CSUP_LINE_ET;
                idle_run_reg <= 1'b0;
            end
            idle_reg <= idle_reg - 5'd1;
        end else if (line_reg == `CSUP_LINE_CH && state_reg != csup_pkg::ST_OFF
                     && state_reg != csup_pkg::ST_CH_ONLY) begin
            line_reg <= `CSUP_LINE_ET;
        end
    end

    // Line and status shown; with errors the top line is the newest fault
    always_ff @(posedge clk) begin
        if (rst) begin
            disp_line   <= `CSUP_LINE_ET;
            disp_status <= csup_pkg::PS_NONE;
        end else begin
            disp_line <= (line_reg == `CSUP_LINE_ET && any_err) ? pt_line(top_pt_reg) : line_reg;
            if (disp_line >= `CSUP_LINE_PT0 && disp_line < `CSUP_LINE_PT0 + 4'd8) begin
                if (sensor_lost[3'(disp_line - `CSUP_LINE_PT0)]
                    && 3'(disp_line - `CSUP_LINE_PT0) != `CSUP_PT_OIL) begin
                    disp_status <= csup_pkg::PS_FAIL;
                end else if (err_reg[3'(disp_line - `CSUP_LINE_PT0)]) begin
                    disp_status <= csup_pkg::PS_ERR;
                end else begin
                    disp_status <= csup_pkg::PS_OK;
                end
            end else begin
                disp_status <= csup_pkg::PS_NONE;
            end
        end
    end

    // Wishbone slave, one wait state, unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `CSUP_CTRL_RESET;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                     && wb_adr_i == `CSUP_ADR_CTRL) begin
            ctrl_reg <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_adr_i == `CSUP_ADR_CTRL) begin
                wb_dat_o <= {30'h0, ctrl_reg};
            end else if (wb_adr_i == `CSUP_ADR_STATUS) begin
                wb_dat_o <= {8'h0, err_reg, 4'h0, remote_reg, retry_reg, 3'h0, state_reg};
            end else if (wb_adr_i == `CSUP_ADR_DISP) begin
                wb_dat_o <= {26'h0, disp_status, disp_line};
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end

endmodule
`default_nettype wire

/* File: dv/csup_supervisor_assertions.sv */
// Port checker for the compressor supervisor
`timescale 1ns/1ps
`default_nettype none
module csup_sup_checker #(
    parameter int SEC_CYCLES = 10
) (
    // Clock, reset, bus
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // Panel and connector
    input wire logic       btn_off,
    input wire logic       btn_up,
    input wire logic       btn_down,
    input wire logic       mode_remote,
    input wire logic       rem_halt,
    input wire logic       rem_alarm,
    input wire logic       rem_shutdown,
    // Fault comparators
    input wire logic       he_temp_hi,
    input wire logic       water_temp_hi,
    input wire logic       water_flow_lo,
    input wire logic       motor_prot_open,
    input wire logic       phase_fault,
    input wire logic       ret_press_lo,
    input wire logic       cable_mismatch,
    // Outputs
    input wire logic       comp_on,
    input wire logic       coldhead_on,
    input wire logic [3:0] disp_line,
    input wire logic [1:0] disp_status
);
    localparam int IDLE_MAX = 30 * SEC_CYCLES + 2;
    localparam int CH_MAX = 1800 * SEC_CYCLES + 3;
    logic        mode_q;
    logic        first_q;
    logic [31:0] idle_cnt;
    logic [31:0] ch_cnt;
    wire         shut_in = he_temp_hi | motor_prot_open | phase_fault | ret_press_lo | cable_mismatch;
    // Mode frozen at the first edge after reset, like the block
    always_ff @(posedge clk) begin
        first_q <= rst;
        if (first_q && !rst) begin
            mode_q <= mode_remote;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || $rose(btn_up) || $rose(btn_down)) begin
            idle_cnt <= '0;
        end else if (idle_cnt <= IDLE_MAX) begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || comp_on || !coldhead_on) begin
            ch_cnt <= '0;
        end else begin
            ch_cnt <= ch_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_stopped;
        !comp_on && !coldhead_on;
    endsequence
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_reset_outs: assert property (disable iff (1'b0) rst |=> s_stopped ##0 disp_status == 2'h3)
        else $error("reset values wrong");
    a_ack_next: assert property (s_bus_req |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_off_stops: assert property (!mode_q && $rose(btn_off) |-> ##3 s_stopped)
        else $error("off button did not stop");
    a_halt_stops: assert property (mode_q && rem_halt |-> ##3 s_stopped)
        else $error("remote halt did not stop");
    a_shut_stops: assert property (shut_in |-> ##2 s_stopped)
        else $error("shutdown left a motor on");
    a_shut_flag: assert property (shut_in |-> ##2 rem_shutdown)
        else $error("shutdown not signalled");
    a_alarm_flag: assert property (water_temp_hi || water_flow_lo |-> ##2 rem_alarm)
        else $error("alarm not signalled");
    a_idle_home: assert property (idle_cnt > IDLE_MAX && !rem_alarm && !rem_shutdown |-> disp_line == 4'h0)
        else $error("display did not return home");
    a_ch_limit: assert property (ch_cnt <= CH_MAX)
        else $error("head-only run too long");
endmodule
`default_nettype wire

/* File: dv/csup_remote_model.sv */
// Remote controller model on the diagnostic connector
`timescale 1ns/1ps
`default_nettype none
module csup_remote_model #(
    parameter int HOLD_CYCLES = 4
) (
    // Clock
    input wire logic clk,
    // Indications from the block
    input wire logic rem_alarm,
    input wire logic rem_shutdown,
    // Commands to the block
    output logic     rem_run,
    output logic     rem_halt,
    output logic     rem_clear
);
    initial begin
        {rem_run, rem_halt, rem_clear} = 3'b000;
    end
    task automatic command(input logic run);
        @(posedge clk);
        rem_run <= run;
        rem_halt <= !run;
        repeat (HOLD_CYCLES) @(posedge clk);
        rem_halt <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic send_clear(output logic ok);
        @(posedge clk);
        rem_clear <= 1'b1;
        repeat (HOLD_CYCLES) @(posedge clk);
        rem_clear <= 1'b0;
        repeat (4) @(posedge clk);
        ok = !rem_alarm && !rem_shutdown;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the compressor supervisor
`timescale 1ns/1ps
`default_nettype none
`include "csup_regs.svh"
module tb_top;
    localparam int SEC = 10;
    logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mode_remote, nv_clean_stop, nv_clean_stop_set;
    logic        rem_run, rem_halt, rem_clear, rem_alarm, rem_shutdown, comp_on, coldhead_on, ok;
    logic [3:0]  wb_adr_i, wb_sel_i, disp_line, btns;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0]  disp_status;
    logic [6:0]  flt;
    logic [7:0]  sensor_lost;
    logic [63:0] rd_q[$];
    logic [63:0] note;
    int          err_total, compares, seed;
    csup_supervisor #(.SEC_CYCLES(SEC)) u_csup_supervisor (
        .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .btn_on(btns[0]), .btn_off(btns[1]), .btn_up(btns[2]), .btn_down(btns[3]), .mode_remote,
        .rem_run, .rem_halt, .rem_clear, .rem_alarm, .rem_shutdown, .nv_clean_stop, .nv_clean_stop_set,
        .he_temp_hi(flt[0]), .water_temp_hi(flt[1]), .water_flow_lo(flt[2]), .motor_prot_open(flt[3]),
        .phase_fault(flt[4]), .ret_press_lo(flt[5]), .cable_mismatch(flt[6]), .sensor_lost,
        .comp_on, .coldhead_on, .disp_line, .disp_status);
    csup_remote_model u_csup_remote_model (.clk, .rem_alarm, .rem_shutdown, .rem_run, .rem_halt, .rem_clear);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [63:0] n);
        chk(got & n[31:0], n[63:32]);
    endtask
    // Read notes are matched to acks in issue order
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && !wb_we_i) begin
            note = rd_q.size() > 0 ? rd_q.pop_front() : 64'hFFFFFFFF_00000000;
            chk_rd(wb_dat_o, note);
        end
    end
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [63:0] n);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        if (!w) rd_q.push_back(n);
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(a, 1'b0, 32'h0, {e, m});
    endtask
    task automatic press(input logic [3:0] m);
        @(posedge clk);
        btns <= m;
        @(posedge clk);
        btns <= 4'h0;
        tick(4);
    endtask
    task automatic do_reset(input logic rmt, input logic clean);
        @(posedge clk);
        rst <= 1'b1;
        mode_remote <= rmt;
        nv_clean_stop <= clean;
        tick(8);
        rst <= 1'b0;
        tick(2);
    endtask
    task automatic close_out;
        $display("Checks made: %0d, mismatches: %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        tick(100000);
        err_total++;
        close_out();
    end
    initial begin
        seed = 56;
        {rst, mode_remote, nv_clean_stop} = 3'b101;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, btns, flt, sensor_lost} = '0;
        wb_sel_i = 4'hF;
        do_reset(1'b0, 1'b1);
        chk({comp_on, coldhead_on, rem_alarm, rem_shutdown, disp_status}, 32'h3);
        rd(`CSUP_ADR_STATUS, 32'hF1F, 32'h001);
        wb(`CSUP_ADR_CTRL, 1'b1, 32'h3, 64'h0);
        rd(`CSUP_ADR_CTRL, 32'h3, 32'h3);
        wb(4'hC, 1'b1, $random(seed), 64'h0);
        rd(4'hC, 32'hFFFFFFFF, 32'h0);
        $display("test bus_reset done");
        for (int i = 1; i <= 12; i++) begin
            press(4'h8);
            chk(disp_line, i % 12);
        end
        press(4'h4);
        chk(disp_line, `CSUP_LINE_CH);
        tick(30 * SEC + 10);
        chk(disp_line, 4'h0);
        press(4'h4);
        press(4'h1);
        chk({comp_on, coldhead_on}, 32'h1);
        tick(1800 * SEC - 40);
        chk(coldhead_on, 1'b1);
        tick(60);
        chk(coldhead_on, 1'b0);
        $display("test display_headonly done");
        press(4'h1);
        chk({comp_on, coldhead_on}, 32'h3);
        press(4'h4);
        chk(disp_line, `CSUP_LINE_LAST_RUN);
        u_csup_remote_model.command(1'b0);
        chk(comp_on, 1'b1);
        for (int i = 1; i < 7; i++) begin
            press(4'h1);
            flt <= 7'h1 << i;
            tick(6);
            chk({rem_shutdown, rem_alarm, comp_on}, i > 2 ? 32'h4 : 32'h3);
            chk(disp_status, csup_pkg::PS_ERR);
            rd(`CSUP_ADR_STATUS, 32'hFF0000, i < 6 ? 32'h10000 << i : 32'h800000);
            flt <= 7'h0;
            press(4'hC);
            chk({rem_shutdown, rem_alarm}, 32'h0);
        end
        sensor_lost <= 8'h40;
        tick(6);
        chk({rem_shutdown, rem_alarm}, 32'h0);
        sensor_lost <= 8'h20;
        tick(6);
        chk(disp_status, csup_pkg::PS_FAIL);
        flt <= 7'h10;
        tick(6);
        chk(disp_status, csup_pkg::PS_ERR);
        rd(`CSUP_ADR_STATUS, 32'hFF0000, 32'h300000);
        {flt, sensor_lost} <= '0;
        press(4'hC);
        press(4'h1);
        press(4'h2);
        chk({comp_on, coldhead_on, rem_shutdown}, 32'h0);
        $display("test faults done");
        press(4'h1);
        flt <= 7'h1;
        tick(6);
        chk({comp_on, rem_shutdown}, 32'h1);
        for (int k = 1; k <= 5; k++) begin
            tick(1200 * SEC);
            rd(`CSUP_ADR_STATUS, 32'h700, k << 8);
        end
        rd(`CSUP_ADR_STATUS, 32'h71F, 32'h501);
        flt <= 7'h0;
        press(4'hC);
        rd(`CSUP_ADR_STATUS, 32'h700, 32'h0);
        $display("test helium_retry done");
        do_reset(1'b0, 1'b0);
        tick(5 * SEC - 12);
        chk(comp_on, 1'b0);
        tick(20);
        chk({comp_on, coldhead_on, nv_clean_stop_set}, 32'h6);
        $display("test power_loss done");
        do_reset(1'b1, 1'b1);
        mode_remote <= 1'b0;
        press(4'h1);
        chk(comp_on, 1'b0);
        u_csup_remote_model.command(1'b1);
        chk(comp_on, 1'b1);
        flt <= 7'h10;
        tick(6);
        flt <= 7'h0;
        press(4'hC);
        chk(rem_shutdown, 1'b1);
        u_csup_remote_model.send_clear(ok);
        chk(ok, 1'b1);
        u_csup_remote_model.command(1'b0);
        chk(comp_on, 1'b0);
        $display("test remote done");
        close_out();
    end
endmodule
bind csup_supervisor csup_sup_checker #(.SEC_CYCLES(SEC_CYCLES)) u_csup_sup_checker (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .btn_off, .btn_up, .btn_down, .mode_remote, .rem_halt,
    .rem_alarm, .rem_shutdown, .he_temp_hi, .water_temp_hi, .water_flow_lo, .motor_prot_open, .phase_fault,
    .ret_press_lo, .cable_mismatch, .comp_on, .coldhead_on, .disp_line, .disp_status);
`default_nettype wire
